// ===== hdl/itra_host_ctrl.sv
`timescale 1ns/1ps
`include "itra_defs.svh"

module itra_host_ctrl #(
  parameter int IDLE_SUS_CYC = `ITRA_IDLE_SUS_CYC
) (
  input wire logic core_clk,            // system clock, 20 MHz
  input wire logic rst_n,               // async reset, active low
  input wire logic cmd_valid,           // command offered
  output logic cmd_ready,               // controller idle, takes command
  input wire itra_pkg::itra_cmd_s cmd,  // command fields
  input wire logic device_suspend,      // target is in suspend mode
  output logic rd_valid,                // one-cycle pulse, rd_data new
  output logic [7:0] rd_data,           // received byte
  output logic done,                    // one-cycle pulse at end of stop
  output logic nack_err,                // target refused a byte
  output logic scl_o,                   // clock pin output value
  output logic scl_oe,                  // clock pin pulled low
  input wire logic sda_i,               // data pin level
  output logic sda_o,                   // data pin output value
  output logic sda_oe                   // data pin pulled low
);

  itra_pkg::itra_state_e st;
  itra_pkg::itra_phase_e ph;
  itra_pkg::itra_cmd_s cmd_q;
  logic [3:0] tick_cnt;
  logic tick;
  logic [1:0] q;
  logic [3:0] bi;
  logic [7:0] tx;
  logic [7:0] rx;
  logic [3:0] left;
  logic nack_s;
  logic wrote;
  logic [`ITRA_WAIT_W-1:0] wait_cnt;
  logic sda_meta;
  logic sda_s;
  logic next_scl_oe;
  logic next_sda_oe;
  logic last_bit;
  logic [6:0] tgt_addr;

  // both lines are open drain: only ever pulled low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign cmd_ready = (st == itra_pkg::S_IDLE);
  assign last_bit = (st == itra_pkg::S_BIT) && tick && (q == 2'h3) && (bi == `ITRA_ACK_BIT);
  assign tgt_addr = cmd_q.addr_sel ? `ITRA_TGT_ADDR_HIGH : `ITRA_TGT_ADDR_LOW;

  // two-stage synchroniser for the data pin
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      sda_meta <= sda_i;
      sda_s <= sda_meta;
    end
  end

  // quarter-bit timebase; held at zero while idle so a frame starts aligned
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 4'h0;
    end else if (st == itra_pkg::S_IDLE || st == itra_pkg::S_WAIT || tick) begin
      tick_cnt <= 4'h0;
    end else begin
      tick_cnt <= tick_cnt + 4'h1;
    end
  end
  assign tick = (tick_cnt == 4'(`ITRA_QTR_CYC - 1));

  // line levels wanted for the current state and quarter
  always_comb begin
    next_scl_oe = 1'b0;
    next_sda_oe = 1'b0;
    unique case (st)
      itra_pkg::S_IDLE, itra_pkg::S_WAIT: begin
        next_scl_oe = 1'b0;
      end
      itra_pkg::S_START: begin
        next_sda_oe = (q != 2'h0);
        next_scl_oe = (q == 2'h2);
      end
      itra_pkg::S_BIT: begin
        next_scl_oe = (q < 2'h2);
        if (ph == itra_pkg::PH_RDATA) begin
          // release during data, ack to continue, release as not-acknowledge on last
          next_sda_oe = (bi == `ITRA_ACK_BIT) && (left != 4'h0);
        end else begin
          // transmitter releases the line in the acknowledge slot
          next_sda_oe = (bi != `ITRA_ACK_BIT) && !tx[7];
        end
      end
      itra_pkg::S_RSTART: begin
        next_scl_oe = (q == 2'h0) || (q == 2'h3);
        next_sda_oe = (q >= 2'h2);
      end
      itra_pkg::S_STOP: begin
        next_scl_oe = (q == 2'h0);
        next_sda_oe = (q < 2'h2);
      end
      default: begin
        next_scl_oe = 1'b0;
      end
    endcase
  end

  // data changes one cycle after the clock falls, never while it falls
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_oe <= next_scl_oe;
      if (!(!scl_oe && next_scl_oe)) begin
        sda_oe <= next_sda_oe;
      end
    end
  end

  // frame sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= itra_pkg::S_IDLE;
      ph <= itra_pkg::PH_ADDRW;
      cmd_q <= '0;
      q <= 2'h0;
      bi <= 4'h0;
      tx <= 8'h00;
      left <= 4'h0;
      wrote <= 1'b0;
      wait_cnt <= '0;
      done <= 1'b0;
      nack_err <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st)
        itra_pkg::S_IDLE: begin
          if (cmd_valid) begin
            cmd_q <= cmd;
            st <= itra_pkg::S_START;
            ph <= itra_pkg::PH_ADDRW;
            q <= 2'h0;
            bi <= 4'h0;
            tx <= {(cmd.addr_sel ? `ITRA_TGT_ADDR_HIGH : `ITRA_TGT_ADDR_LOW), `ITRA_RW_WRITE};
            left <= cmd.rd_len;
            wrote <= cmd.write;
            nack_err <= 1'b0;
          end
        end
        itra_pkg::S_START: begin
          if (tick) begin
            q <= q + 2'h1;
            if (q == 2'h2) begin
              st <= itra_pkg::S_BIT;
              q <= 2'h0;
            end
          end
        end
        itra_pkg::S_BIT: begin
          if (tick) begin
            q <= q + 2'h1;
            if (q == 2'h3 && bi != `ITRA_ACK_BIT) begin
              bi <= bi + 4'h1;
              tx <= {tx[6:0], 1'b0};
            end
          end
          if (last_bit) begin
            bi <= 4'h0;
            // a refused address, register or write data byte aborts with stop
            if (ph != itra_pkg::PH_RDATA && nack_s) begin
              st <= itra_pkg::S_STOP;
              nack_err <= 1'b1;
            end else begin
              unique case (ph)
                itra_pkg::PH_ADDRW: begin
                  ph <= itra_pkg::PH_REGA;
                  tx <= cmd_q.reg_addr;
                end
                itra_pkg::PH_REGA: begin
                  if (cmd_q.write) begin
                    ph <= itra_pkg::PH_WDATA;
                    tx <= cmd_q.wdata;
                  end else begin
                    // repeated start, no stop, between the phases
                    st <= itra_pkg::S_RSTART;
                    tx <= {tgt_addr, `ITRA_RW_READ};
                    ph <= itra_pkg::PH_ADDRR;
                  end
                end
                itra_pkg::PH_WDATA: begin
                  st <= itra_pkg::S_STOP;
                end
                itra_pkg::PH_ADDRR: begin
                  ph <= itra_pkg::PH_RDATA;
                end
                itra_pkg::PH_RDATA: begin
                  if (left == 4'h0) begin
                    st <= itra_pkg::S_STOP;
                  end else begin
                    left <= left - 4'h1;
                  end
                end
                default: begin
                  st <= itra_pkg::S_STOP;
                end
              endcase
            end
          end
        end
        itra_pkg::S_RSTART: begin
          if (tick) begin
            q <= q + 2'h1;
            if (q == 2'h3) begin
              st <= itra_pkg::S_BIT;
            end
          end
        end
        itra_pkg::S_STOP: begin
          if (tick) begin
            q <= q + 2'h1;
            if (q == 2'h3) begin
              // stop after the target has released the line
              st <= itra_pkg::S_WAIT;
              done <= 1'b1;
              if (wrote && device_suspend) begin
                wait_cnt <= `ITRA_WAIT_W'(IDLE_SUS_CYC - 1);
              end else if (wrote) begin
                wait_cnt <= `ITRA_WAIT_W'(`ITRA_IDLE_NM_CYC - 1);
              end else begin
                wait_cnt <= `ITRA_WAIT_W'(`ITRA_BUF_CYC - 1);
              end
            end
          end
        end
        itra_pkg::S_WAIT: begin
          if (wait_cnt == '0) begin
            st <= itra_pkg::S_IDLE;
          end else begin
            wait_cnt <= wait_cnt - `ITRA_WAIT_W'(1);
          end
        end
        default: begin
          st <= itra_pkg::S_IDLE;
        end
      endcase
    end
  end

  // sample mid-high: shift data bits in MSB first, catch the target's acknowledge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx <= 8'h00;
      nack_s <= 1'b0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (st == itra_pkg::S_BIT && tick && q == 2'h2) begin
        if (bi == `ITRA_ACK_BIT) begin
          nack_s <= sda_s;
        end else begin
          rx <= {rx[6:0], sda_s};
        end
      end
      if (st == itra_pkg::S_BIT && tick && q == 2'h3 && bi == 4'h7 && ph == itra_pkg::PH_RDATA) begin
        rd_data <= rx;
        rd_valid <= 1'b1;
      end
    end
  end

  // helper: cycles spent in the idle gap, read only by checks
  logic [`ITRA_WAIT_W-1:0] wait_len;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_len <= '0;
    end else if (st == itra_pkg::S_WAIT) begin
      wait_len <= wait_len + `ITRA_WAIT_W'(1);
    end else begin
      wait_len <= '0;
    end
  end

  // checks on the frame sequencer and line drive
  property p_rstart_between;
    @(posedge core_clk) disable iff (!rst_n)
      (last_bit && ph == itra_pkg::PH_REGA && !cmd_q.write && !nack_s) |=> (st == itra_pkg::S_RSTART);
  endproperty
  a_rstart_between: assert property (p_rstart_between) else $error("read did not use repeated start");

  property p_write_addr;
    @(posedge core_clk) disable iff (!rst_n)
      (st == itra_pkg::S_START && tick && q == 2'h2) |=>
        (ph == itra_pkg::PH_ADDRW && tx == {tgt_addr, `ITRA_RW_WRITE});
  endproperty
  a_write_addr: assert property (p_write_addr) else $error("first byte not address with write bit");

  property p_refused_stops;
    @(posedge core_clk) disable iff (!rst_n)
      (last_bit && ph != itra_pkg::PH_RDATA && nack_s) |=> (st == itra_pkg::S_STOP && nack_err);
  endproperty
  a_refused_stops: assert property (p_refused_stops) else $error("refused byte not ended with stop");

  property p_read_addr;
    @(posedge core_clk) disable iff (!rst_n)
      (st == itra_pkg::S_RSTART && tick && q == 2'h3) |=>
        (st == itra_pkg::S_BIT && ph == itra_pkg::PH_ADDRR && tx == {tgt_addr, `ITRA_RW_READ});
  endproperty
  a_read_addr: assert property (p_read_addr) else $error("read address byte wrong");

  property p_release_data;
    @(posedge core_clk) disable iff (!rst_n)
      (st == itra_pkg::S_BIT && ph == itra_pkg::PH_RDATA && bi != `ITRA_ACK_BIT && q != 2'h0) |-> !sda_oe;
  endproperty
  a_release_data: assert property (p_release_data) else $error("host drove data line during read byte");

  // scl_oe is registered one cycle behind the quarter count, so the first cycle of Q2 still shows it pulled
  property p_ack_continue;
    @(posedge core_clk) disable iff (!rst_n)
      (st == itra_pkg::S_BIT && ph == itra_pkg::PH_RDATA && bi == `ITRA_ACK_BIT && q >= 2'h2 && tick_cnt != 4'h0)
        |-> (sda_oe == (left != 4'h0)) && !scl_oe;
  endproperty
  a_ack_continue: assert property (p_ack_continue) else $error("host acknowledge level wrong");

  property p_nack_ends;
    @(posedge core_clk) disable iff (!rst_n)
      (last_bit && ph == itra_pkg::PH_RDATA && left == 4'h0) |=> (st == itra_pkg::S_STOP) ##[1:80] done;
  endproperty
  a_nack_ends: assert property (p_nack_ends) else $error("burst not ended after not-acknowledge");

  property p_tx_ack_release;
    @(posedge core_clk) disable iff (!rst_n)
      (st == itra_pkg::S_BIT && ph != itra_pkg::PH_RDATA && bi == `ITRA_ACK_BIT && q != 2'h0) |-> !sda_oe;
  endproperty
  a_tx_ack_release: assert property (p_tx_ack_release) else $error("host held line in target ack slot");

  property p_idle_normal;
    @(posedge core_clk) disable iff (!rst_n)
      (st == itra_pkg::S_WAIT && wait_cnt == '0 && wrote && !device_suspend)
        |-> (wait_len == `ITRA_WAIT_W'(`ITRA_IDLE_NM_CYC - 1));
  endproperty
  a_idle_normal: assert property (p_idle_normal) else $error("normal-mode idle gap wrong");

  property p_idle_suspend;
    @(posedge core_clk) disable iff (!rst_n)
      (st == itra_pkg::S_WAIT && wait_cnt == '0 && wrote && device_suspend)
        |-> (wait_len == `ITRA_WAIT_W'(IDLE_SUS_CYC - 1));
  endproperty
  a_idle_suspend: assert property (p_idle_suspend) else $error("suspend-mode idle gap wrong");

  // the command port may only reopen after a write once the full normal-mode gap has run out
  property p_no_cmd_in_gap;
    @(posedge core_clk) disable iff (!rst_n)
      (cmd_ready && !$past(cmd_ready) && wrote) |-> ($past(wait_len) >= `ITRA_WAIT_W'(`ITRA_IDLE_NM_CYC - 1));
  endproperty
  a_no_cmd_in_gap: assert property (p_no_cmd_in_gap) else $error("command taken during idle gap");

  c_burst: cover property (@(posedge core_clk) disable iff (!rst_n)
    (last_bit && ph == itra_pkg::PH_RDATA && left == 4'h0 && cmd_q.rd_len != 4'h0));
  c_write: cover property (@(posedge core_clk) disable iff (!rst_n) (done && wrote && !nack_err));
  c_refused: cover property (@(posedge core_clk) disable iff (!rst_n) (done && nack_err));

endmodule : itra_host_ctrl

// ===== shared/itra_defs.svh
`ifndef ITRA_DEFS_SVH
`define ITRA_DEFS_SVH

`define ITRA_CLK_MHZ 20
// quarter of one serial bit; 4 quarters give 1.4 us low and 1.4 us high
`define ITRA_QTR_NS 700
`define ITRA_QTR_CYC ((`ITRA_QTR_NS * `ITRA_CLK_MHZ + 999) / 1000)
// bus free time after a stop
`define ITRA_BUF_NS 1300
`define ITRA_BUF_CYC ((`ITRA_BUF_NS * `ITRA_CLK_MHZ + 999) / 1000)
`define ITRA_IDLE_NM_US 2
`define ITRA_IDLE_NM_CYC (`ITRA_IDLE_NM_US * `ITRA_CLK_MHZ)
`define ITRA_IDLE_SUS_US 450
`define ITRA_IDLE_SUS_CYC (`ITRA_IDLE_SUS_US * `ITRA_CLK_MHZ)

`define ITRA_TGT_ADDR_LOW 7'h18
`define ITRA_TGT_ADDR_HIGH 7'h19
`define ITRA_RW_WRITE 1'b0
`define ITRA_RW_READ 1'b1
`define ITRA_ACK_BIT 4'h8
`define ITRA_WAIT_W 14

`endif

// ===== shared/itra_pkg.sv
package itra_pkg;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_START = 3'b001,
    S_BIT = 3'b010,
    S_RSTART = 3'b011,
    S_STOP = 3'b100,
    S_WAIT = 3'b101
  } itra_state_e;

  typedef enum logic [2:0] {
    PH_ADDRW = 3'b000,
    PH_REGA = 3'b001,
    PH_WDATA = 3'b010,
    PH_ADDRR = 3'b011,
    PH_RDATA = 3'b100
  } itra_phase_e;

  typedef struct packed {
    logic write;          // 1: register write, 0: register read burst
    logic addr_sel;       // level of the target's address_select_pin
    logic [7:0] reg_addr; // register address
    logic [7:0] wdata;    // write data
    logic [3:0] rd_len;   // bytes to read minus one
  } itra_cmd_s;

endpackage : itra_pkg

// ===== tb/itra_target_model.sv
`timescale 1ns/1ps
// behavioural sensor-side target on the pulled-up clock and data wires
module itra_target_model #(
  parameter bit WDT_EN = 1'b1,
  parameter bit WDT_SEL = 1'b0,
  parameter int WDT_NS = 1000000
) (
  input wire logic scl,      // clock wire level
  input wire logic sda,      // data wire level
  input wire logic addr_sel, // address_select_pin level
  output logic sda_oe        // pulls data low
);
  logic [7:0] mem [256];
  logic [7:0] sh, base, ptr;
  logic act, tx, more;
  int cnt, nb;
  realtime t_clk;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
    base = 8'h00;
    sda_oe = 1'b0;
    act = 1'b0;
    tx = 1'b0;
    t_clk = 0;
  end
  // start or repeated start; cnt -1 skips the clock fall that ends the start
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    tx = 1'b0;
    cnt = -1;
    nb = 0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    act = 1'b0;
    sda_oe = 1'b0;
  end
  // sample host bits, and the host acknowledge while sending
  always @(posedge scl) begin
    t_clk = $realtime;
    if (act && cnt < 8 && !tx) sh = {sh[6:0], sda};
    if (act && cnt == 8 && tx) more = !sda;
  end
  // all wire changes happen while the clock is low
  always @(negedge scl) begin
    t_clk = $realtime;
    if (act && cnt == 8) begin
      cnt = 0;
      nb++;
      sda_oe = 1'b0;
      if (tx && !more) act = 1'b0;
      else if (tx) begin
        sh = mem[ptr];
        ptr++;
        sda_oe = !sh[7];
      end
    end else if (act) begin
      cnt++;
      if (tx) sda_oe = (cnt < 8) ? !sh[7 - cnt] : 1'b0;
      else if (cnt == 8 && nb == 0) begin
        sda_oe = (sh[7:1] == {6'h0c, addr_sel});
        act = sda_oe;
        tx = sh[0];
        ptr = base;
        more = 1'b1;
      end else if (cnt == 8) begin
        if (nb == 1) base = sh;
        else mem[base] = sh;
        sda_oe = 1'b1;
      end
    end
  end
  always #1000 if (WDT_EN && sda_oe && $realtime - t_clk > WDT_NS * (WDT_SEL ? 2 : 1)) begin
    sda_oe = 1'b0;
    act = 1'b0;
  end
endmodule : itra_target_model

// ===== tb/itra_host_ctrl_test.sv
`timescale 1ns/1ps
module itra_host_ctrl_test;
  localparam int SUS = 50;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic device_suspend = 1'b0;
  logic pin_sel = 1'b0;
  itra_pkg::itra_cmd_s cmd = '0;
  logic cmd_ready, rd_valid, done, nack_err, scl_oe, sda_oe, sda_oe_t, scl_o, sda_o;
  logic [7:0] rd_data;
  logic [7:0] got [$];
  int gap;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  // both wires are pulled up unless someone pulls low
  wire logic scl = !scl_oe;
  wire logic sda = !(sda_oe | sda_oe_t);

  itra_host_ctrl #(.IDLE_SUS_CYC(SUS)) u_itra_host_ctrl (
    .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .device_suspend(device_suspend), .rd_valid(rd_valid), .rd_data(rd_data), .done(done),
    .nack_err(nack_err), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  itra_target_model u_itra_target_model (.scl(scl), .sda(sda), .addr_sel(pin_sel), .sda_oe(sda_oe_t));

  // 20 MHz system clock
  always #25 core_clk = !core_clk;

  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    return a ^ 8'h3c;
  endfunction : exp_byte

  task automatic chk8(input logic [7:0] a, input logic [7:0] e);
    check_count++;
    if (a !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, a, e);
    end
  endtask : chk8

  task automatic chk_min(input int a, input int lo);
    check_count++;
    if (a < lo) begin
      mismatches++;
      $display("[ERR] %0t gap %0d below %0d", $time, a, lo);
    end
  endtask : chk_min

  // one command: offer, collect bytes until done, then time the idle gap
  task automatic run_cmd(input logic wr, input logic sel, input logic [7:0] ra, input logic [7:0] wd,
                         input logic [3:0] len);
    int k;
    got.delete();
    k = 0;
    do @(negedge core_clk); while (cmd_ready !== 1'b1);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd <= '{write: wr, addr_sel: sel, reg_addr: ra, wdata: wd, rd_len: len};
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && k < 20000) begin
      @(negedge core_clk);
      if (rd_valid === 1'b1) got.push_back(rd_data);
      k++;
    end
    chk8({7'h0, done}, 8'h01);
    gap = 0;
    while (cmd_ready !== 1'b1 && gap < 20000) begin
      @(negedge core_clk);
      gap++;
    end
  endtask : run_cmd

  task automatic t_write_read;
    run_cmd(1'b1, 1'b0, 8'h12, 8'h5a, 4'h0);
    chk_min(gap, 40);
    run_cmd(1'b0, 1'b0, 8'h12, 8'h00, 4'h3);
    chk8(8'(got.size()), 8'h04);
    for (int i = 0; i < 4; i++) chk8(got[i], i == 0 ? 8'h5a : exp_byte(8'h12 + 8'(i)));
    $display("test write_read done");
  endtask : t_write_read

  // longest burst from each target address
  task automatic t_long_read;
    for (int s = 0; s < 2; s++) begin
      @(posedge core_clk);
      pin_sel <= 1'(s);
      run_cmd(1'b0, 1'(s), 8'h40, 8'h00, 4'hf);
      chk8(8'(got.size()), 8'h10);
      for (int i = 0; i < 16; i++) chk8(got[i], exp_byte(8'h40 + 8'(i)));
      chk8({6'h0, scl, sda}, 8'h03);
    end
    $display("test long_read done");
  endtask : t_long_read

  // wrong address is refused, next command clears the flag
  task automatic t_addr_refused;
    @(posedge core_clk);
    pin_sel <= 1'b0;
    run_cmd(1'b0, 1'b1, 8'h10, 8'h00, 4'h1);
    chk8({7'h0, nack_err}, 8'h01);
    chk8(8'(got.size()), 8'h00);
    run_cmd(1'b0, 1'b0, 8'h10, 8'h00, 4'h0);
    chk8({7'h0, nack_err}, 8'h00);
    chk8(got[0], exp_byte(8'h10));
    $display("test addr_refused done");
  endtask : t_addr_refused

  task automatic t_suspend_gap;
    @(posedge core_clk);
    device_suspend <= 1'b1;
    run_cmd(1'b1, 1'b0, 8'h7e, 8'hc3, 4'h0);
    chk_min(gap, SUS);
    @(posedge core_clk);
    device_suspend <= 1'b0;
    run_cmd(1'b0, 1'b0, 8'h7e, 8'h00, 4'h1);
    chk8(got[0], 8'hc3);
    chk8(got[1], exp_byte(8'h7f));
    $display("test suspend_gap done");
  endtask : t_suspend_gap

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // a hang is cut short well above the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      $display("[ERR] %0t run too long", $time);
      complete_run();
    end
  end

  // reset for 5 cycles, then the scenarios
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk8({4'h0, cmd_ready, scl_oe, sda_oe, nack_err}, 8'h08);
    chk8({6'h0, scl_o, sda_o}, 8'h00);
    t_write_read();
    t_long_read();
    t_addr_refused();
    t_suspend_gap();
    complete_run();
  end
endmodule : itra_host_ctrl_test
